// ==== rfsr_bus_master.sv ====
// bus master model that frames register writes and reads
`timescale 1ns/10ps
module rfsr_bus_master (
    // clock
    input wire logic i_clock,
    // slave drive
    input wire logic i_sdata,
    input wire logic i_sdata_oe_n,
    // bus pins
    output logic o_sclk,
    output logic o_sdata
);
    logic m_sd = 1'b0;
    // released line toggles, so a stale bit never reads as good data
    assign o_sdata = i_sdata_oe_n ? m_sd : i_sdata;
    initial o_sclk = 1'b0;
    // both clock phases are eight system clocks, twice the minimum
    task automatic half();
        repeat (8) @(negedge i_clock);
    endtask
    task automatic bits(input logic [12:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            o_sclk = 1'b1;
            m_sd = v[i];
            half();
            o_sclk = 1'b0;
            half();
        end
    endtask
    task automatic frame(input logic [3:0] sa, input logic [7:0] cmd);
        m_sd = 1'b1;
        half();
        m_sd = 1'b0;
        half();
        bits({sa, cmd, ~^{sa, cmd}}, 13);
    endtask
    task automatic wr(input logic [3:0] sa, input logic [7:0] cmd,
        input logic [7:0] d, input logic has_d);
        frame(sa, cmd);
        if (has_d)
            bits({4'h0, d, ~^d}, 9);
        bits(13'h0000, 1);
    endtask
    task automatic rd(input logic [3:0] sa, input logic [4:0] a,
        output logic [8:0] q, output logic hi);
        hi = 1'b1;
        frame(sa, {3'b011, a});
        bits(13'h0000, 1);
        for (int i = 8; i >= 0; i--)
        begin
            o_sclk = 1'b1;
            m_sd = ~m_sd;
            half();
            q[i] = o_sdata;
            hi = hi & i_sdata_oe_n;
            o_sclk = 1'b0;
            half();
        end
        bits(13'h0000, 1);
    endtask
endmodule

// ==== rfsr_defs.svh ====
// register map offsets, reset values, fields and opcodes of the slave
`ifndef RFSR_DEFS_SVH
`define RFSR_DEFS_SVH

`define RFSR_A_ENABLES 8'h00
`define RFSR_A_ROUTING 8'h01
`define RFSR_A_BOOST 8'h02
`define RFSR_A_TIMER_A 8'h03
`define RFSR_A_TIMER_C 8'h05
`define RFSR_A_SET_A 8'h06
`define RFSR_A_SET_C 8'h08
`define RFSR_A_RDMODE 8'h09
`define RFSR_A_SPARE_LO 8'h0A
`define RFSR_A_SPARE_HI 8'h17
`define RFSR_A_SID1 8'h18
`define RFSR_A_SID2 8'h19
`define RFSR_A_STATUS 8'h1A
`define RFSR_A_GROUP 8'h1B
`define RFSR_A_PMTRIG 8'h1C
`define RFSR_A_PID 8'h1D
`define RFSR_A_MFR 8'h1E
`define RFSR_A_SID0 8'h1F
`define RFSR_A_LAST 8'h1F

`define RFSR_SPARE_WORDS 14

`define RFSR_RST_ENABLES 3'h0
`define RFSR_RST_ROUTING 6'h3F
`define RFSR_RST_BOOST 8'hDB
`define RFSR_RST_CHAN 8'h00
`define RFSR_RST_RDMODE 8'h00
`define RFSR_RST_SID 4'h7
`define RFSR_RST_GROUP 8'h00
`define RFSR_RST_PM 2'h0
`define RFSR_RST_MASK 3'h7
`define RFSR_RST_STATUS 8'h00

`define RFSR_BOOST_WMASK 8'hDF
`define RFSR_BC_SID 4'h0

`define RFSR_PM_HI 7
`define RFSR_PM_LO 6
`define RFSR_MASK_LO 3

`define RFSR_ST_RURE 0
`define RFSR_ST_WURE 1
`define RFSR_ST_CPERR 2
`define RFSR_ST_DPERR 3

`define RFSR_OP_WR 3'h2
`define RFSR_OP_RD 3'h3
`define RFSR_OP_EXT_WR 4'h0
`define RFSR_OP_EXT_RD 4'h2
`define RFSR_OP_EXT_WRL 5'h06
`define RFSR_OP_EXT_RDL 5'h07

`endif

// ==== rfsr_pin_sync.sv ====
// two-flop synchroniser for the bus pins and the otp bit
`timescale 1ns/10ps
module rfsr_pin_sync (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // asynchronous levels
    input wire logic [2:0] i_async,
    // synchronised levels
    output logic [2:0] o_sync
);

    logic [2:0] meta_ff;

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            meta_ff <= 3'h0;
            o_sync <= 3'h0;
        end
        else
        begin
            meta_ff <= i_async;
            o_sync <= meta_ff;
        end
    end

endmodule

// ==== rfsr_pkg.sv ====
// types shared by the serial slave register map
package rfsr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SA,
        ST_CMD,
        ST_ADDR,
        ST_WDATA,
        ST_PARK,
        ST_RDATA,
        ST_RPARK
    } rfsr_state_t;

    typedef struct packed {
        logic [1:0] power_mode;
        logic read_mode;
        logic [7:0] boost;
        logic [2:0] enables;
        logic [2:0][7:0] timer;
        logic [2:0][7:0] setting;
    } rfsr_ctrl_t;

endpackage

// ==== rfsr_regmap.sv ====
// serial front-end slave: frame decoder and thirty-two-register map
`timescale 1ns/10ps
`include "rfsr_defs.svh"
module rfsr_regmap #(
    parameter logic [9:0] P_MFR_ID = 10'h155, // arbitrary value
    parameter logic [6:0] P_PID_UPPER = 7'h2A // arbitrary value
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // serial bus pins
    input wire logic i_sclk,
    input wire logic i_sdata,
    output logic o_sdata,
    output logic o_sdata_oe_n,
    // otp product id bit
    input wire logic i_otp_pid_bit,
    // settings to the output channels
    output rfsr_pkg::rfsr_ctrl_t o_ctrl
);

    logic [2:0] pin_s;
    logic sclk_s, sdata_s, otp_s;
    logic sclk_d_ff, sdata_d_ff, ssc_arm_ff;
    logic rise, fall, ssc_start;
    rfsr_pkg::rfsr_state_t state_ff;
    logic [3:0] cnt_ff, sa_ff, left_ff;
    logic [12:0] sh_ff;
    logic [12:0] frm;
    logic [7:0] addr_ff;
    logic ext_rd_ff, rd_ok_ff;
    logic [8:0] rsh_ff;
    logic wr_go_ff;
    logic [7:0] wr_addr_ff, wr_data_ff;
    logic [3:0] st_set_ff;
    logic [2:0] enables_ff;
    logic [5:0] routing_ff;
    logic [7:0] boost_ff, rdmode_ff, group_ff, status_ff;
    logic [2:0][7:0] tmr_sh_ff, tmr_act_ff, set_sh_ff, set_act_ff;
    logic [2:0][3:0] sid_ff;
    logic [1:0] pm_ff;
    logic [2:0] mask_ff;
    logic [2:0] id_hit;
    logic bc_hit;
    logic [7:0] rd_val, spare_roff, spare_woff, spare_rdata;
    logic [2:0] fire;

    rfsr_pin_sync u_sync (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_async({i_otp_pid_bit, i_sdata, i_sclk}),
        .o_sync(pin_s)
    );

    assign sclk_s = pin_s[0];
    assign sdata_s = pin_s[1];
    assign otp_s = pin_s[2];

    // trigger mask bit selected by a two-bit id-select code; code 3 selects all three bits
    function automatic logic [2:0] dur_sel(input logic [1:0] dur);
        dur_sel = (dur == 2'h3) ? 3'h7 : 3'(3'h1 << dur);
    endfunction

    function automatic logic [1:0] chan_of(input logic [7:0] a);
        chan_of = (a >= `RFSR_A_SET_A) ? 2'(a - `RFSR_A_SET_A)
                                       : 2'(a - `RFSR_A_TIMER_A);
    endfunction

    // who may reach a register; broadcast never reads
    function automatic logic access_ok(input logic [7:0] a,
        input logic is_rd, input logic [2:0] hit, input logic bc,
        input logic [5:0] rt);
        logic bcx;
        logic [1:0] c;
        bcx = bc & ~is_rd;
        c = chan_of(a);
        if (a > `RFSR_A_LAST)
            access_ok = 1'b0;
        else if (a >= `RFSR_A_TIMER_A && a <= `RFSR_A_SET_C)
            access_ok = |(dur_sel(rt[2*c +: 2]) & hit);
        else if (a == `RFSR_A_SID0)
            access_ok = hit[0] | bcx;
        else if (a == `RFSR_A_SID1)
            access_ok = hit[1] | bcx;
        else if (a == `RFSR_A_SID2)
            access_ok = hit[2] | bcx;
        else if (a == `RFSR_A_PMTRIG)
            access_ok = (|hit) | bcx;
        else
            access_ok = |hit;
    endfunction

    // channel write lands at once when its selected triggers are masked
    function automatic logic imm_load(input logic [1:0] dur,
        input logic [2:0] mask);
        imm_load = (dur_sel(dur) & ~mask) == 3'h0;
    endfunction

    assign rise = sclk_s & ~sclk_d_ff;
    assign fall = ~sclk_s & sclk_d_ff;
    assign frm = {sh_ff[11:0], sdata_s};
    assign ssc_start = ssc_arm_ff & ~sclk_s & sdata_d_ff & ~sdata_s
                       & state_ff != rfsr_pkg::ST_RDATA
                       & state_ff != rfsr_pkg::ST_RPARK;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            id_hit[i] = sa_ff == sid_ff[i];
        end
        bc_hit = sa_ff == `RFSR_BC_SID || sa_ff == group_ff[3:0];
    end

    // sequence start: data pulses high then low while clock is low
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            sclk_d_ff <= 1'b0;
            sdata_d_ff <= 1'b0;
            ssc_arm_ff <= 1'b0;
        end
        else
        begin
            sclk_d_ff <= sclk_s;
            sdata_d_ff <= sdata_s;
            if (sclk_s || ssc_start)
                ssc_arm_ff <= 1'b0;
            else if (sdata_s && !sdata_d_ff)
                ssc_arm_ff <= 1'b1;
        end
    end

    // frame decoder; bits are taken on the falling clock edge
    always_ff @(posedge i_clock)
    begin
        wr_go_ff <= 1'b0;
        st_set_ff <= 4'h0;
        if (!i_nrst)
        begin
            state_ff <= rfsr_pkg::ST_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 13'h0000;
            sa_ff <= 4'h0;
            left_ff <= 4'h0;
            addr_ff <= 8'h00;
            ext_rd_ff <= 1'b0;
            rd_ok_ff <= 1'b0;
            rsh_ff <= 9'h000;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
            o_sdata <= 1'b0;
            o_sdata_oe_n <= 1'b1;
        end
        else if (ssc_start)
        begin
            state_ff <= rfsr_pkg::ST_SA;
            cnt_ff <= 4'h0;
        end
        else if (fall)
        begin
            sh_ff <= frm;
            cnt_ff <= cnt_ff + 4'h1;
            unique case (state_ff)
                rfsr_pkg::ST_IDLE:
                begin
                    cnt_ff <= 4'h0;
                end
                rfsr_pkg::ST_SA:
                begin
                    if (cnt_ff == 4'h3)
                    begin
                        sa_ff <= frm[3:0];
                        cnt_ff <= 4'h0;
                        state_ff <= rfsr_pkg::ST_CMD;
                    end
                end
                rfsr_pkg::ST_CMD:
                begin
                    if (cnt_ff == 4'h8)
                    begin
                        cnt_ff <= 4'h0;
                        state_ff <= rfsr_pkg::ST_IDLE;
                        left_ff <= 4'h0;
                        addr_ff <= {3'h0, frm[5:1]};
                        if (!(|id_hit) && !bc_hit)
                            state_ff <= rfsr_pkg::ST_IDLE;
                        else if (!(^frm))
                            st_set_ff[`RFSR_ST_CPERR] <= 1'b1;
                        else if (frm[8])
                        begin
                            wr_go_ff <= access_ok(`RFSR_A_ENABLES, 1'b0,
                                id_hit, bc_hit, routing_ff);
                            wr_addr_ff <= `RFSR_A_ENABLES;
                            wr_data_ff <= {1'b0, frm[7:1]};
                        end
                        else if (frm[8:6] == `RFSR_OP_WR)
                            state_ff <= rfsr_pkg::ST_WDATA;
                        else if (frm[8:6] == `RFSR_OP_RD)
                            state_ff <= rfsr_pkg::ST_PARK;
                        else if (frm[8:5] == `RFSR_OP_EXT_WR ||
                                 frm[8:5] == `RFSR_OP_EXT_RD)
                        begin
                            left_ff <= frm[4:1];
                            ext_rd_ff <= frm[6];
                            state_ff <= rfsr_pkg::ST_ADDR;
                        end
                        else if (frm[8:4] == `RFSR_OP_EXT_WRL)
                            st_set_ff[`RFSR_ST_WURE] <= 1'b1;
                        else if (frm[8:4] == `RFSR_OP_EXT_RDL)
                            st_set_ff[`RFSR_ST_RURE] <= 1'b1;
                    end
                end
                rfsr_pkg::ST_ADDR:
                begin
                    if (cnt_ff == 4'h8)
                    begin
                        cnt_ff <= 4'h0;
                        addr_ff <= frm[8:1];
                        if (!(^frm[8:0]))
                        begin
                            st_set_ff[`RFSR_ST_DPERR] <= 1'b1;
                            state_ff <= rfsr_pkg::ST_IDLE;
                        end
                        else if (ext_rd_ff)
                            state_ff <= rfsr_pkg::ST_PARK;
                        else
                            state_ff <= rfsr_pkg::ST_WDATA;
                    end
                end
                rfsr_pkg::ST_WDATA:
                begin
                    if (cnt_ff == 4'h8)
                    begin
                        cnt_ff <= 4'h0;
                        wr_addr_ff <= addr_ff;
                        wr_data_ff <= frm[8:1];
                        addr_ff <= addr_ff + 8'h01;
                        left_ff <= left_ff - 4'h1;
                        if (!(^frm[8:0]))
                        begin
                            st_set_ff[`RFSR_ST_DPERR] <= 1'b1;
                            state_ff <= rfsr_pkg::ST_IDLE;
                        end
                        else
                        begin
                            wr_go_ff <= access_ok(addr_ff, 1'b0, id_hit,
                                bc_hit, routing_ff);
                            if (left_ff == 4'h0)
                                state_ff <= rfsr_pkg::ST_IDLE;
                        end
                    end
                end
                rfsr_pkg::ST_PARK:
                begin
                    cnt_ff <= 4'h0;
                    rsh_ff <= {rd_val, ~^rd_val};
                    rd_ok_ff <= access_ok(addr_ff, 1'b1, id_hit, bc_hit,
                        routing_ff);
                    state_ff <= rfsr_pkg::ST_RDATA;
                end
                rfsr_pkg::ST_RDATA:
                begin
                    cnt_ff <= cnt_ff;
                    // step the address one bit early: spare reads lag
                    if (cnt_ff == 4'h8 && left_ff != 4'h0)
                        addr_ff <= addr_ff + 8'h01;
                    if (cnt_ff == 4'h9 && left_ff == 4'h0)
                        state_ff <= rfsr_pkg::ST_RPARK;
                    else if (cnt_ff == 4'h9)
                    begin
                        cnt_ff <= 4'h0;
                        left_ff <= left_ff - 4'h1;
                        rsh_ff <= {rd_val, ~^rd_val};
                        rd_ok_ff <= access_ok(addr_ff, 1'b1, id_hit,
                            bc_hit, routing_ff);
                    end
                end
                rfsr_pkg::ST_RPARK:
                begin
                    o_sdata_oe_n <= 1'b1;
                    state_ff <= rfsr_pkg::ST_IDLE;
                end
            endcase
        end
        else if (rise && state_ff == rfsr_pkg::ST_RDATA && cnt_ff != 4'h9)
        begin
            o_sdata <= rsh_ff[8];
            o_sdata_oe_n <= ~rd_ok_ff;
            rsh_ff <= {rsh_ff[7:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
        end
        else if (rise && state_ff == rfsr_pkg::ST_RPARK)
        begin
            o_sdata <= 1'b0;
        end
    end

    // plain control registers
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            enables_ff <= `RFSR_RST_ENABLES;
            routing_ff <= `RFSR_RST_ROUTING;
            boost_ff <= `RFSR_RST_BOOST;
            rdmode_ff <= `RFSR_RST_RDMODE;
            group_ff <= `RFSR_RST_GROUP;
            pm_ff <= `RFSR_RST_PM;
            mask_ff <= `RFSR_RST_MASK;
            for (int i = 0; i < 3; i++)
            begin
                sid_ff[i] <= `RFSR_RST_SID;
            end
        end
        else if (wr_go_ff)
        begin
            case (wr_addr_ff)
                `RFSR_A_ENABLES: enables_ff <= wr_data_ff[2:0];
                `RFSR_A_ROUTING: routing_ff <= wr_data_ff[5:0];
                `RFSR_A_BOOST: boost_ff <= wr_data_ff & `RFSR_BOOST_WMASK;
                `RFSR_A_RDMODE: rdmode_ff <= wr_data_ff;
                `RFSR_A_GROUP: group_ff <= wr_data_ff;
                `RFSR_A_SID0: sid_ff[0] <= wr_data_ff[3:0];
                `RFSR_A_SID1: sid_ff[1] <= wr_data_ff[3:0];
                `RFSR_A_SID2: sid_ff[2] <= wr_data_ff[3:0];
                `RFSR_A_PMTRIG:
                begin
                    pm_ff <= wr_data_ff[`RFSR_PM_HI:`RFSR_PM_LO];
                    mask_ff <= wr_data_ff[`RFSR_MASK_LO +: 3];
                end
                default: ;
            endcase
        end
    end

    // hardware-set status bits win over a software write
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            status_ff <= `RFSR_RST_STATUS;
        else if (wr_go_ff && wr_addr_ff == `RFSR_A_STATUS)
            status_ff <= wr_data_ff | {4'h0, st_set_ff};
        else
            status_ff <= status_ff | {4'h0, st_set_ff};
    end

    // triggers fire only where their mask bit is clear
    assign fire = (wr_go_ff && wr_addr_ff == `RFSR_A_PMTRIG)
                  ? wr_data_ff[2:0] & ~wr_data_ff[`RFSR_MASK_LO +: 3]
                  : 3'h0;

    // channel shadow and active copies
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            for (int c = 0; c < 3; c++)
            begin
                tmr_sh_ff[c] <= `RFSR_RST_CHAN;
                tmr_act_ff[c] <= `RFSR_RST_CHAN;
                set_sh_ff[c] <= `RFSR_RST_CHAN;
                set_act_ff[c] <= `RFSR_RST_CHAN;
            end
        end
        else
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (|(fire & dur_sel(routing_ff[2*c +: 2])))
                begin
                    tmr_act_ff[c] <= tmr_sh_ff[c];
                    set_act_ff[c] <= set_sh_ff[c];
                end
                if (wr_go_ff && wr_addr_ff == `RFSR_A_TIMER_A + 8'(c))
                begin
                    tmr_sh_ff[c] <= wr_data_ff;
                    if (imm_load(routing_ff[2*c +: 2], mask_ff))
                        tmr_act_ff[c] <= wr_data_ff;
                end
                if (wr_go_ff && wr_addr_ff == `RFSR_A_SET_A + 8'(c))
                begin
                    set_sh_ff[c] <= wr_data_ff;
                    if (imm_load(routing_ff[2*c +: 2], mask_ff))
                        set_act_ff[c] <= wr_data_ff;
                end
            end
        end
    end

    assign spare_woff = wr_addr_ff - `RFSR_A_SPARE_LO;
    assign spare_roff = addr_ff - `RFSR_A_SPARE_LO;

    rfsr_spare_mem u_spare (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_we(wr_go_ff && wr_addr_ff >= `RFSR_A_SPARE_LO
              && wr_addr_ff <= `RFSR_A_SPARE_HI),
        .i_waddr(spare_woff[3:0]),
        .i_wdata(wr_data_ff),
        .i_raddr(spare_roff[3:0]),
        .o_rdata(spare_rdata)
    );

    // read value; timer and setting return the active copy
    always_comb
    begin
        rd_val = 8'h00;
        if (addr_ff >= `RFSR_A_SPARE_LO && addr_ff <= `RFSR_A_SPARE_HI)
            rd_val = spare_rdata;
        else if (addr_ff >= `RFSR_A_TIMER_A && addr_ff <= `RFSR_A_TIMER_C)
            rd_val = tmr_act_ff[chan_of(addr_ff)];
        else if (addr_ff >= `RFSR_A_SET_A && addr_ff <= `RFSR_A_SET_C)
            rd_val = set_act_ff[chan_of(addr_ff)];
        else
        begin
            case (addr_ff)
                `RFSR_A_ENABLES: rd_val = {5'h00, enables_ff};
                `RFSR_A_ROUTING: rd_val = {2'h0, routing_ff};
                `RFSR_A_BOOST: rd_val = boost_ff;
                `RFSR_A_RDMODE: rd_val = rdmode_ff;
                `RFSR_A_SID0: rd_val = {2'h0, P_MFR_ID[9:8], sid_ff[0]};
                `RFSR_A_SID1: rd_val = {2'h0, P_MFR_ID[9:8], sid_ff[1]};
                `RFSR_A_SID2: rd_val = {2'h0, P_MFR_ID[9:8], sid_ff[2]};
                `RFSR_A_STATUS: rd_val = status_ff;
                `RFSR_A_GROUP: rd_val = group_ff;
                `RFSR_A_PMTRIG: rd_val = {pm_ff, mask_ff, 3'h0};
                `RFSR_A_PID: rd_val = {P_PID_UPPER, otp_s};
                `RFSR_A_MFR: rd_val = P_MFR_ID[7:0];
                default: rd_val = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        o_ctrl.power_mode = pm_ff;
        o_ctrl.read_mode = rdmode_ff[0];
        o_ctrl.boost = boost_ff;
        o_ctrl.enables = enables_ff;
        o_ctrl.timer = tmr_act_ff;
        o_ctrl.setting = set_act_ff;
    end

endmodule

// ==== rfsr_regmap_assertions.sv ====
// port checker for the serial slave register map
`timescale 1ns/10ps
module rfsr_regmap_assertions (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // bus pins and settings
    input wire logic i_sclk,
    input wire logic o_sdata,
    input wire logic o_sdata_oe_n,
    input rfsr_pkg::rfsr_ctrl_t o_ctrl
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    reset_out_a: assert property (
        $rose(i_nrst) |-> o_sdata_oe_n && o_ctrl.boost == 8'hDB
        && o_ctrl.enables == 3'h0) else $error("bad reset outputs");
    reset_chan_a: assert property (
        $rose(i_nrst) |-> o_ctrl.setting == '0 && o_ctrl.timer == '0
        && o_ctrl.power_mode == 2'h0) else $error("bad reset settings");
    boost_spare_a: assert property (
        o_ctrl.boost[5] == 1'b0) else $error("boost spare bit set");
    ctrl_on_fall_a: assert property (
        $changed(o_ctrl) |-> !i_sclk) else $error("settings moved early");
    drive_on_rise_a: assert property (
        $fell(o_sdata_oe_n) |-> i_sclk && $past(i_sclk, 2))
        else $error("drive not after clock rise");
    data_on_rise_a: assert property (
        $changed(o_sdata) && !o_sdata_oe_n |-> i_sclk)
        else $error("read bit moved with clock low");
    bus_release_a: assert property (
        $rose(o_sdata_oe_n) |-> !i_sclk) else $error("release off fall");
    drive_hold_a: assert property (
        $fell(o_sdata_oe_n) |-> (!o_sdata_oe_n) [*8])
        else $error("drive too short");
    bit_hold_a: assert property (
        $fell(o_sdata_oe_n) |=> $stable(o_sdata) [*6])
        else $error("read bit too short");
endmodule
bind rfsr_regmap rfsr_regmap_assertions chk (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_sclk(i_sclk), .o_sdata(o_sdata),
    .o_sdata_oe_n(o_sdata_oe_n), .o_ctrl(o_ctrl));

// ==== rfsr_spare_mem.sv ====
// spare register words, registered read port
`timescale 1ns/10ps
`include "rfsr_defs.svh"
module rfsr_spare_mem (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // write port
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // read port
    input wire logic [3:0] i_raddr,
    output logic [7:0] o_rdata
);

    logic [7:0] mem_ff [0:`RFSR_SPARE_WORDS-1];

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            for (int i = 0; i < `RFSR_SPARE_WORDS; i++)
            begin
                mem_ff[i] <= 8'h00;
            end
        end
        else if (i_we)
        begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end

    // out-of-range index reads zero rather than an unknown word
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_raddr < 4'(`RFSR_SPARE_WORDS))
        begin
            o_rdata <= mem_ff[i_raddr];
        end
        else
        begin
            o_rdata <= 8'h00;
        end
    end

endmodule

// ==== tb_rfsr_regmap.sv ====
// self-checking bench for the serial slave register map
`timescale 1ns/10ps
module tb_rfsr_regmap;
    localparam logic [9:0] MFR = 10'h2C6; // arbitrary value
    localparam logic [6:0] PIDU = 7'h15; // arbitrary value
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic i_otp_pid_bit = 1'b1;
    logic sclk;
    logic sdata;
    logic o_sdata;
    logic o_sdata_oe_n;
    logic hi;
    logic [8:0] q;
    rfsr_pkg::rfsr_ctrl_t o_ctrl;
    int err_count = 0;
    int n_compared = 0;
    rfsr_regmap #(.P_MFR_ID(MFR), .P_PID_UPPER(PIDU)) uut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_sclk(sclk),
        .i_sdata(sdata), .o_sdata(o_sdata), .o_sdata_oe_n(o_sdata_oe_n),
        .i_otp_pid_bit(i_otp_pid_bit), .o_ctrl(o_ctrl));
    rfsr_bus_master mst (.i_clock(i_clock), .i_sdata(o_sdata),
        .i_sdata_oe_n(o_sdata_oe_n), .o_sclk(sclk), .o_sdata(sdata));
    always #20 i_clock = ~i_clock;
    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [8:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic w(input logic [3:0] sa, input logic [4:0] a,
        input logic [7:0] d);
        mst.wr(sa, {3'b010, a}, d, 1'b1);
    endtask
    task automatic rchk(input logic [3:0] sa, input logic [4:0] a,
        input logic [7:0] d);
        mst.rd(sa, a, q, hi);
        check($sformatf("reg %h", a), q, {d, ~^d});
        check("drive", 9'(hi), 9'h000);
    endtask
    initial
    begin
        #2_000_000;
        err_count++;
        end_of_test();
    end
    initial
    begin
        repeat (12) @(negedge i_clock);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_clock);
        check("boost", 9'(o_ctrl.boost), 9'h0DB);
        rchk(4'h7, 5'h02, 8'hDB);
        rchk(4'h7, 5'h01, 8'h3F);
        rchk(4'h7, 5'h1E, MFR[7:0]);
        rchk(4'h7, 5'h18, {2'b00, MFR[9:8], 4'h7});
        rchk(4'h7, 5'h19, {2'b00, MFR[9:8], 4'h7});
        rchk(4'h7, 5'h1D, {PIDU, 1'b1});
        i_otp_pid_bit = 1'b0;
        w(4'h7, 5'h1D, 8'hFF);
        rchk(4'h7, 5'h1D, {PIDU, 1'b0});
        w(4'h7, 5'h0A, 8'hA5);
        w(4'h7, 5'h17, 8'h3C);
        rchk(4'h7, 5'h0A, 8'hA5);
        rchk(4'h7, 5'h17, 8'h3C);
        mst.frame(4'h7, 8'h00);
        mst.bits({4'h0, 8'h0A, ~^8'h0A}, 9);
        mst.bits({4'h0, 8'h5C, ~^8'h5C}, 9);
        mst.bits(13'h0000, 1);
        rchk(4'h7, 5'h0A, 8'h5C);
        w(4'h7, 5'h1F, 8'hFF);
        rchk(4'hF, 5'h1F, {2'b00, MFR[9:8], 4'hF});
        mst.wr(4'h7, 8'h85, 8'h00, 1'b0);
        check("enables", 9'(o_ctrl.enables), 9'h005);
        w(4'h7, 5'h06, 8'h5A);
        check("set a", 9'(o_ctrl.setting[0]), 9'h05A);
        rchk(4'h7, 5'h06, 8'h5A);
        w(4'h7, 5'h03, 8'h2D);
        check("timer a", 9'(o_ctrl.timer[0]), 9'h02D);
        rchk(4'h7, 5'h03, 8'h2D);
        w(4'h7, 5'h01, 8'h00);
        w(4'h7, 5'h07, 8'h77);
        check("set b", 9'(o_ctrl.setting[1]), 9'h000);
        w(4'hF, 5'h07, 8'h77);
        check("set b", 9'(o_ctrl.setting[1]), 9'h077);
        w(4'h0, 5'h1C, 8'hB0);
        check("pm", 9'(o_ctrl.power_mode), 9'h002);
        w(4'hF, 5'h08, 8'h33);
        check("set c", 9'(o_ctrl.setting[2]), 9'h000);
        w(4'hF, 5'h05, 8'h44);
        check("timer c", 9'(o_ctrl.timer[2]), 9'h000);
        w(4'h0, 5'h1C, 8'hB1);
        check("set c", 9'(o_ctrl.setting[2]), 9'h033);
        check("timer c", 9'(o_ctrl.timer[2]), 9'h044);
        rchk(4'h7, 5'h1C, 8'hB0);
        w(4'h7, 5'h1B, 8'h05);
        rchk(4'h7, 5'h1B, 8'h05);
        w(4'h5, 5'h1C, 8'hF8);
        check("pm", 9'(o_ctrl.power_mode), 9'h003);
        w(4'h7, 5'h09, 8'h01);
        check("rdmode", 9'(o_ctrl.read_mode), 9'h001);
        rchk(4'hF, 5'h09, 8'h01);
        mst.wr(4'h7, 8'h30, 8'h00, 1'b0);
        rchk(4'h7, 5'h1A, 8'h02);
        mst.rd(4'h0, 5'h02, q, hi);
        check("no drive", 9'(hi), 9'h001);
        mst.rd(4'h3, 5'h02, q, hi);
        check("no drive", 9'(hi), 9'h001);
        end_of_test();
    end
endmodule
